// >>> rtl/sktd_defs.svh
// Constants for the skip test instruction decoder
`ifndef SKTD_DEFS_SVH
`define SKTD_DEFS_SVH

// Opcodes of the four skip tests
`define SKTD_OP_CONV_DONE 10'h287
`define SKTD_OP_EXT0_PIN 10'h03A
`define SKTD_OP_EXT1_PIN 10'h03B
`define SKTD_OP_PWR_DOWN 10'h003

// Bit positions inside the control registers
`define SKTD_CONV_EN_BIT 2
`define SKTD_EXT0_POL_BIT 2
`define SKTD_EXT1_POL_BIT 2

// Word offsets on the register bus (byte addresses)
`define SKTD_ADR_CTL_TWO 8'h00
`define SKTD_ADR_CTL_EXT0 8'h04
`define SKTD_ADR_CTL_EXT1 8'h08
`define SKTD_ADR_STATUS 8'h0C
`define SKTD_ADR_IRQ_STAT 8'h10
`define SKTD_ADR_IRQ_MASK 8'h14

// Reset values
`define SKTD_RST_CTL 4'h0
`define SKTD_RST_MASK 4'h0

// Interrupt status bit positions
`define SKTD_EV_SKIP 0
`define SKTD_EV_CONV 1
`define SKTD_EV_EXT0 2
`define SKTD_EV_EXT1 3

`endif

// >>> rtl/sktd_pkg.sv
// Types shared by the skip test instruction decoder
`default_nettype none
package sktd_pkg;

   typedef enum logic [2:0] {
      SKTD_OP_NONE = 3'b000,
      SKTD_OP_CONV = 3'b001,
      SKTD_OP_EXT0 = 3'b010,
      SKTD_OP_EXT1 = 3'b011,
      SKTD_OP_PWR = 3'b100
   } sktd_op_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } sktd_wb_req_t;

   typedef struct packed {
      logic [2:0] pin0_sync;
      logic [2:0] pin1_sync;
      logic pin0_lvl;
      logic pin1_lvl;
      logic conv_flag;
      logic skip_pend;
      logic [3:0] hit;
      logic [3:0] ctl_two;
      logic [3:0] ctl_ext0;
      logic [3:0] ctl_ext1;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic irq;
      logic ack;
      logic [31:0] rdat;
      logic carry_keep;
   } sktd_state_t;

endpackage
`default_nettype wire

// >>> rtl/sktd_decoder.sv
// Skip test instruction decoder with its control registers
// Contract
// RL1: Opcode 287h decodes as the one-cycle converter-done test; carry untouched.
// RL2: Enable bit 0: skip next instruction when the conversion flag is set.
// RL3: A converter-done skip clears the conversion flag in the same instruction.
// RL4: Enable bit 1: converter-done test is a no-op, flag unchanged.
// RL5: The converter enable is bit 2 of the second control register.
// RL6: Opcode 03Ah decodes as the one-cycle pin 0 test; carry untouched.
// RL7: Polarity 0: skip when pin 0 is low, else execute next.
// RL8: Polarity 1: skip when pin 0 is high, else execute next.
// RL9: Pin 0 polarity is bit 2 of the pin 0 control register.
// RL10: Opcode 03Bh decodes as the one-cycle pin 1 test; carry untouched.
// RL11: Polarity 0: skip when pin 1 is low, else execute next.
// RL12: Polarity 1: skip when pin 1 is high, else execute next.
// RL13: Pin 1 polarity is bit 2 of the pin 1 control register.
// RL14: Opcode 003h decodes as the one-cycle power-down test; carry untouched.
// RL15: Skip when the power-down flag is 1; flag never changed.
// RL16: A skipped instruction uses its cycle but has no effect at all.
`timescale 1ns/100ps
`default_nettype none
`include "sktd_defs.svh"

module sktd_decoder (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_issue,
   input wire logic [9:0] i_opcode,
   input wire logic i_conv_done,
   input wire logic i_powerdown_flag,
   input wire logic i_ext_irq_pin_0,
   input wire logic i_ext_irq_pin_1,
   input wire sktd_pkg::sktd_wb_req_t i_wb,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   output logic o_irq,
   output logic o_skip_next,
   output logic [3:0] o_dec_hit,
   output logic o_carry_keep,
   output logic o_conversion_complete_flag,
   output logic [3:0] o_irq_control_reg_two,
   output logic [3:0] o_ext0_irq_control_reg,
   output logic [3:0] o_ext1_irq_control_reg
);
   import sktd_pkg::*;

   sktd_state_t st_r;
   sktd_state_t st_nxt;

   // Exact ten-bit match; anything else is not ours
   function automatic sktd_op_t sktd_decode(input logic [9:0] op);
      sktd_op_t k;
      k = SKTD_OP_NONE;
      if (op == `SKTD_OP_CONV_DONE) begin
         k = SKTD_OP_CONV; // RL1
      end else if (op == `SKTD_OP_EXT0_PIN) begin
         k = SKTD_OP_EXT0; // RL6
      end else if (op == `SKTD_OP_EXT1_PIN) begin
         k = SKTD_OP_EXT1; // RL10
      end else if (op == `SKTD_OP_PWR_DOWN) begin
         k = SKTD_OP_PWR; // RL14
      end
      return k;
   endfunction

   logic conv_en;
   logic ext0_match;
   logic ext1_match;
   logic irq_any;
   logic bus_req;
   sktd_op_t op_now;

   assign conv_en = st_r.ctl_two[`SKTD_CONV_EN_BIT]; // RL5
   // Skip when the filtered level equals the polarity bit
   assign ext0_match = (st_r.pin0_lvl ==
      st_r.ctl_ext0[`SKTD_EXT0_POL_BIT]); // RL9
   assign ext1_match = (st_r.pin1_lvl ==
      st_r.ctl_ext1[`SKTD_EXT1_POL_BIT]); // RL13
   assign irq_any = |(st_r.irq_stat & st_r.irq_mask);
   assign bus_req = i_wb.cyc && i_wb.stb && !st_r.ack;
   // A pending skip squashes whatever is issued next
   assign op_now = (i_issue && !st_r.skip_pend) ?
      sktd_decode(i_opcode) : SKTD_OP_NONE; // RL16

   always_comb begin
      logic conv_clr;
      logic skip;
      logic ev_ext0;
      logic ev_ext1;
      logic [3:0] ev;
      logic rd_stat;
      conv_clr = 1'b0;
      skip = 1'b0;
      ev_ext0 = 1'b0;
      ev_ext1 = 1'b0;
      ev = 4'h0;
      rd_stat = 1'b0;
      st_nxt = st_r;

      // Pins come from outside: three stages, level moves when 2 and 3 agree
      st_nxt.pin0_sync = {st_r.pin0_sync[1:0], i_ext_irq_pin_0};
      st_nxt.pin1_sync = {st_r.pin1_sync[1:0], i_ext_irq_pin_1};
      if (st_r.pin0_sync[2] == st_r.pin0_sync[1]) begin
         st_nxt.pin0_lvl = st_r.pin0_sync[2];
         ev_ext0 = (st_r.pin0_sync[2] != st_r.pin0_lvl);
      end
      if (st_r.pin1_sync[2] == st_r.pin1_sync[1]) begin
         st_nxt.pin1_lvl = st_r.pin1_sync[2];
         ev_ext1 = (st_r.pin1_sync[2] != st_r.pin1_lvl);
      end

      st_nxt.hit = 4'h0;
      unique case (op_now)
         SKTD_OP_NONE: begin
            skip = 1'b0;
         end
         SKTD_OP_CONV: begin
            st_nxt.hit = 4'h1; // RL1
            if (!conv_en && st_r.conv_flag) begin
               skip = 1'b1; // RL2
               conv_clr = 1'b1; // RL3
            end
            // With the enable set: no skip and no flag clear, only the hit RL4
         end
         SKTD_OP_EXT0: begin
            st_nxt.hit = 4'h2; // RL6
            skip = ext0_match; // RL7 RL8
         end
         SKTD_OP_EXT1: begin
            st_nxt.hit = 4'h4; // RL10
            skip = ext1_match; // RL11 RL12
         end
         SKTD_OP_PWR: begin
            st_nxt.hit = 4'h8; // RL14
            skip = i_powerdown_flag; // RL15
         end
      endcase
      st_nxt.carry_keep = |st_nxt.hit; // RL1 RL6 RL10 RL14

      // The skip waits for the next issue, however long that takes
      if (i_issue) begin
         st_nxt.skip_pend = skip; // RL16
      end

      // A new conversion result beats a clear in the same cycle
      st_nxt.conv_flag = (st_r.conv_flag && !conv_clr) || i_conv_done; // RL3

      // Register bus: one wait state, ack dropped after one cycle
      st_nxt.ack = bus_req;
      if (bus_req && i_wb.we && i_wb.sel[0]) begin
         if (i_wb.adr == `SKTD_ADR_CTL_TWO) begin
            st_nxt.ctl_two = i_wb.dat[3:0];
         end
         if (i_wb.adr == `SKTD_ADR_CTL_EXT0) begin
            st_nxt.ctl_ext0 = i_wb.dat[3:0];
         end
         if (i_wb.adr == `SKTD_ADR_CTL_EXT1) begin
            st_nxt.ctl_ext1 = i_wb.dat[3:0];
         end
         if (i_wb.adr == `SKTD_ADR_IRQ_MASK) begin
            st_nxt.irq_mask = i_wb.dat[3:0];
         end
      end
      if (bus_req) begin
         st_nxt.rdat = 32'h0000_0000;
         if (!i_wb.we) begin
            unique case (i_wb.adr)
               `SKTD_ADR_CTL_TWO: st_nxt.rdat[3:0] = st_r.ctl_two;
               `SKTD_ADR_CTL_EXT0: st_nxt.rdat[3:0] = st_r.ctl_ext0;
               `SKTD_ADR_CTL_EXT1: st_nxt.rdat[3:0] = st_r.ctl_ext1;
               `SKTD_ADR_STATUS: st_nxt.rdat[3:0] = {i_powerdown_flag,
                  st_r.pin1_lvl, st_r.pin0_lvl, st_r.conv_flag};
               `SKTD_ADR_IRQ_STAT: begin
                  st_nxt.rdat[3:0] = st_r.irq_stat;
                  rd_stat = 1'b1;
               end
               `SKTD_ADR_IRQ_MASK: st_nxt.rdat[3:0] = st_r.irq_mask;
               default: st_nxt.rdat = 32'h0000_0000;
            endcase
         end
      end

      // Sticky events; an event in the read-clear cycle survives
      ev[`SKTD_EV_SKIP] = skip;
      ev[`SKTD_EV_CONV] = i_conv_done;
      ev[`SKTD_EV_EXT0] = ev_ext0;
      ev[`SKTD_EV_EXT1] = ev_ext1;
      st_nxt.irq_stat = (rd_stat ? 4'h0 : st_r.irq_stat) | ev;
      st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r.pin0_sync <= 3'h0;
         st_r.pin1_sync <= 3'h0;
         st_r.pin0_lvl <= 1'b0;
         st_r.pin1_lvl <= 1'b0;
         st_r.conv_flag <= 1'b0;
         st_r.skip_pend <= 1'b0;
         st_r.hit <= 4'h0;
         st_r.ctl_two <= `SKTD_RST_CTL;
         st_r.ctl_ext0 <= `SKTD_RST_CTL;
         st_r.ctl_ext1 <= `SKTD_RST_CTL;
         st_r.irq_stat <= 4'h0;
         st_r.irq_mask <= `SKTD_RST_MASK;
         st_r.irq <= 1'b0;
         st_r.ack <= 1'b0;
         st_r.rdat <= 32'h0000_0000;
         st_r.carry_keep <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_wb_ack = st_r.ack;
   assign o_wb_dat = st_r.rdat;
   assign o_irq = st_r.irq;
   assign o_skip_next = st_r.skip_pend;
   assign o_dec_hit = st_r.hit;
   // None of these tests ever writes the carry
   assign o_carry_keep = st_r.carry_keep;
   assign o_conversion_complete_flag = st_r.conv_flag;
   assign o_irq_control_reg_two = st_r.ctl_two;
   assign o_ext0_irq_control_reg = st_r.ctl_ext0;
   assign o_ext1_irq_control_reg = st_r.ctl_ext1;

   // Checks
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   logic pend_d;
   logic conv_d;
   assign pend_d = st_r.skip_pend;
   assign conv_d = st_r.conv_flag;

   sequence s_live_issue;
      i_issue && !st_r.skip_pend;
   endsequence
   sequence s_conv;
      s_live_issue ##0 (i_opcode == `SKTD_OP_CONV_DONE);
   endsequence
   sequence s_ext0;
      s_live_issue ##0 (i_opcode == `SKTD_OP_EXT0_PIN);
   endsequence
   sequence s_ext1;
      s_live_issue ##0 (i_opcode == `SKTD_OP_EXT1_PIN);
   endsequence
   sequence s_pwr;
      s_live_issue ##0 (i_opcode == `SKTD_OP_PWR_DOWN);
   endsequence

   // Helpers for the bus checks
   logic [3:0] wr_nib;
   logic mask_wr;
   assign wr_nib = i_wb.dat[3:0];
   assign mask_wr = bus_req && i_wb.we && i_wb.sel[0] &&
      (i_wb.adr == `SKTD_ADR_IRQ_MASK);

   sequence s_any_test;
      s_live_issue ##0 (i_opcode == `SKTD_OP_CONV_DONE ||
         i_opcode == `SKTD_OP_EXT0_PIN || i_opcode == `SKTD_OP_EXT1_PIN ||
         i_opcode == `SKTD_OP_PWR_DOWN);
   endsequence
   // Ack is one cycle wide, so a request still held is not taken twice
   sequence s_ack_pulse;
      st_r.ack ##1 !st_r.ack;
   endsequence

   AST_CONV_HIT: assert property (s_conv |=> st_r.hit == 4'h1) // RL1
      else $error("converter test not decoded");

   AST_CONV_SKIP: assert property ( // RL2
      s_conv ##0 (!conv_en && conv_d) |=> pend_d)
      else $error("converter test failed to skip");

   AST_CONV_EXEC: assert property ( // RL2
      s_conv ##0 (!conv_en && !conv_d) |=> !pend_d)
      else $error("converter test skipped with the flag clear");

   AST_CONV_CLEAR: assert property ( // RL3
      s_conv ##0 (!conv_en && conv_d && !i_conv_done) |=> !conv_d)
      else $error("conversion flag not cleared on skip");

   AST_CONV_NOP: assert property ( // RL4
      s_conv ##0 conv_en |=> !pend_d && (conv_d == $past(conv_d)
      || $past(i_conv_done)))
      else $error("disabled converter test had an effect");

   AST_CTL_TWO_WR: assert property ( // RL5
      (bus_req && i_wb.we && i_wb.sel[0] &&
      i_wb.adr == `SKTD_ADR_CTL_TWO) |=> st_r.ctl_two == $past(wr_nib))
      else $error("converter enable register write lost");

   AST_EXT0: assert property ( // RL6
      s_ext0 |=> st_r.hit == 4'h2 && pend_d == $past(ext0_match))
      else $error("pin 0 test skip wrong");

   AST_EXT0_LOW: assert property ( // RL7
      s_ext0 ##0 (!st_r.ctl_ext0[`SKTD_EXT0_POL_BIT] && !st_r.pin0_lvl)
      |=> pend_d)
      else $error("pin 0 low test did not skip");

   AST_EXT0_HIGH: assert property ( // RL8
      s_ext0 ##0 (st_r.ctl_ext0[`SKTD_EXT0_POL_BIT] && st_r.pin0_lvl)
      |=> pend_d)
      else $error("pin 0 high test did not skip");

   AST_EXT0_EXEC: assert property ( // RL9
      s_ext0 ##0 (st_r.ctl_ext0[`SKTD_EXT0_POL_BIT] != st_r.pin0_lvl)
      |=> !pend_d)
      else $error("pin 0 test skipped on the wrong level");

   AST_EXT1: assert property ( // RL10
      s_ext1 |=> st_r.hit == 4'h4 && pend_d == $past(ext1_match))
      else $error("pin 1 test skip wrong");

   AST_EXT1_LOW: assert property ( // RL11
      s_ext1 ##0 (!st_r.ctl_ext1[`SKTD_EXT1_POL_BIT] && !st_r.pin1_lvl)
      |=> pend_d)
      else $error("pin 1 low test did not skip");

   AST_EXT1_HIGH: assert property ( // RL12
      s_ext1 ##0 (st_r.ctl_ext1[`SKTD_EXT1_POL_BIT] && st_r.pin1_lvl)
      |=> pend_d)
      else $error("pin 1 high test did not skip");

   AST_EXT1_EXEC: assert property ( // RL13
      s_ext1 ##0 (st_r.ctl_ext1[`SKTD_EXT1_POL_BIT] != st_r.pin1_lvl)
      |=> !pend_d)
      else $error("pin 1 test skipped on the wrong level");

   AST_PWR: assert property ( // RL15
      s_pwr |=> st_r.hit == 4'h8 && pend_d == $past(i_powerdown_flag))
      else $error("power-down test skip wrong");

   AST_CARRY_KEEP: assert property ( // RL1 RL6 RL10 RL14
      s_any_test |=> st_r.carry_keep)
      else $error("carry not held for a skip test");

   AST_SQUASH: assert property ( // RL16
      (i_issue && pend_d && !i_conv_done) |=>
      !pend_d && st_r.hit == 4'h0 && conv_d == $past(conv_d))
      else $error("skipped instruction had an effect");

   AST_PEND_HOLD: assert property ( // RL16
      (pend_d && !i_issue) |=> pend_d)
      else $error("pending skip lost before next issue");

   AST_HIT_ONEHOT: assert property ($onehot0(st_r.hit))
      else $error("more than one test decoded at once");

   AST_ACK_PULSE: assert property (
      (i_wb.cyc && i_wb.stb && !st_r.ack) |=> s_ack_pulse)
      else $error("bus ack not a single cycle");

   AST_IRQ_LEVEL: assert property (
      (i_conv_done && st_r.irq_mask[`SKTD_EV_CONV] && !mask_wr)
      |=> st_r.irq)
      else $error("interrupt not raised for unmasked status");

   AST_IRQ_QUIET: assert property (
      (st_r.irq_mask == 4'h0 && !mask_wr) |=> !st_r.irq)
      else $error("interrupt raised with every source masked");

   AST_CONV_SET: assert property (
      i_conv_done |=> conv_d && st_r.irq_stat[`SKTD_EV_CONV])
      else $error("conversion result lost to a clear");

   AST_STAT_CLEAR: assert property (
      (bus_req && !i_wb.we && i_wb.adr == `SKTD_ADR_IRQ_STAT &&
      !i_conv_done) |=> !st_r.irq_stat[`SKTD_EV_CONV])
      else $error("status read did not clear the event");

   AST_PIN0_FILTER: assert property (
      (st_r.pin0_sync[2] != st_r.pin0_sync[1]) |=> $stable(st_r.pin0_lvl))
      else $error("pin 0 level moved before its stages agreed");

   AST_PIN1_FILTER: assert property (
      (st_r.pin1_sync[2] != st_r.pin1_sync[1]) |=> $stable(st_r.pin1_lvl))
      else $error("pin 1 level moved before its stages agreed");
endmodule
`default_nettype wire

// >>> verif/sktd_core_model.sv
// Core model that issues instruction words to the skip decoder
`timescale 1ns/100ps
`default_nettype none
module sktd_core_model (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_go,
   input wire logic [9:0] i_op,
   output logic o_issue,
   output logic [9:0] o_opcode
);
   // Word flips between issues so a stale opcode never looks valid
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_issue <= 1'b0;
         o_opcode <= 10'h000;
      end else begin
         o_issue <= i_go;
         o_opcode <= i_go ? i_op : ~o_opcode;
      end
   end
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the skip test instruction decoder
`timescale 1ns/100ps
`default_nettype none
`include "sktd_defs.svh"
module testbench;
   import sktd_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic go = 1'b0;
   logic [9:0] op = 10'h000;
   logic cdone = 1'b0;
   logic pwr = 1'b0;
   logic pin0 = 1'b0;
   logic pin1 = 1'b0;
   sktd_wb_req_t wb = '0;
   logic issue, ack, irq, skip, keep, flag;
   logic [9:0] opcode;
   logic [31:0] rdat;
   logic [3:0] hit, ctl2, ctl0, ctl1;
   int n_mismatch = 0;
   int n_checks = 0;
   int cycles = 0;

   always #10 i_core_clk = ~i_core_clk;

   sktd_core_model core (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .i_go(go), .i_op(op), .o_issue(issue), .o_opcode(opcode));

   sktd_decoder uut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .i_issue(issue), .i_opcode(opcode), .i_conv_done(cdone),
      .i_powerdown_flag(pwr), .i_ext_irq_pin_0(pin0),
      .i_ext_irq_pin_1(pin1), .i_wb(wb), .o_wb_ack(ack),
      .o_wb_dat(rdat), .o_irq(irq), .o_skip_next(skip),
      .o_dec_hit(hit), .o_carry_keep(keep),
      .o_conversion_complete_flag(flag),
      .o_irq_control_reg_two(ctl2), .o_ext0_irq_control_reg(ctl0),
      .o_ext1_irq_control_reg(ctl1));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Classic cycle: request held until ack is seen at a rising edge
   task automatic wb_cycle(input logic we, input logic [7:0] adr,
         input logic [31:0] wd, output logic [31:0] rd);
      @(posedge i_core_clk);
      wb <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hF, dat:wd};
      // No limit here: only the bench timeout may end a hung wait
      do begin
         @(posedge i_core_clk);
      end while (ack !== 1'b1);
      rd = rdat;
      wb <= '0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] x;
      wb_cycle(1'b1, adr, d, x);
   endtask

   task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
      logic [31:0] x;
      wb_cycle(1'b0, adr, 32'h0, x);
      chk(x, e);
   endtask

   task automatic pulse_conv;
      @(posedge i_core_clk);
      cdone <= 1'b1;
      @(posedge i_core_clk);
      cdone <= 1'b0;
   endtask

   task automatic issue_word(input logic [9:0] w);
      @(posedge i_core_clk);
      go <= 1'b1;
      op <= w;
      @(posedge i_core_clk);
      go <= 1'b0;
      @(posedge i_core_clk);
      #1;
   endtask

   // Test word twice: a pending skip must squash the repeat entirely
   task automatic run_op(input logic [9:0] w, input logic [31:0] eh,
         input logic [31:0] es);
      issue_word(w);
      chk(hit, eh);
      chk(skip, es);
      chk(keep, 32'(eh != 0));
      issue_word(w);
      chk(hit, es ? 32'h0 : eh);
      chk(skip, 32'h0);
      chk(keep, es ? 32'h0 : 32'(eh != 0));
   endtask

   task automatic t_regs;
      rd_chk(`SKTD_ADR_CTL_TWO, 32'h0);
      wr(`SKTD_ADR_CTL_TWO, 32'h4);
      rd_chk(`SKTD_ADR_CTL_TWO, 32'h4);
      chk(ctl2, 32'h4);
      rd_chk(8'h20, 32'h0);
      wr(`SKTD_ADR_CTL_TWO, 32'h0);
      $display("test regs done");
   endtask

   task automatic t_conv;
      pulse_conv();
      run_op(`SKTD_OP_CONV_DONE, 32'h1, 32'h1);
      chk(flag, 32'h0);
      run_op(`SKTD_OP_CONV_DONE, 32'h1, 32'h0);
      wr(`SKTD_ADR_CTL_TWO, 32'h4);
      pulse_conv();
      run_op(`SKTD_OP_CONV_DONE, 32'h1, 32'h0);
      chk(flag, 32'h1);
      wr(`SKTD_ADR_CTL_TWO, 32'h0);
      run_op(`SKTD_OP_CONV_DONE, 32'h1, 32'h1);
      chk(flag, 32'h0);
      $display("test conv done");
   endtask

   task automatic t_pins;
      logic [7:0] adr;
      logic [9:0] w;
      logic [31:0] eh;
      for (int p = 0; p < 2; p++) begin
         for (int pol = 0; pol < 2; pol++) begin
            for (int lv = 0; lv < 2; lv++) begin
               adr = p ? `SKTD_ADR_CTL_EXT1 : `SKTD_ADR_CTL_EXT0;
               w = p ? `SKTD_OP_EXT1_PIN : `SKTD_OP_EXT0_PIN;
               eh = p ? 32'h4 : 32'h2;
               wr(adr, 32'(pol << 2));
               chk(p ? ctl1 : ctl0, 32'(pol << 2));
               @(posedge i_core_clk);
               pin0 <= (p == 0) ? 1'(lv) : 1'b0;
               pin1 <= (p == 1) ? 1'(lv) : 1'b0;
               // Filtered level lags the pin by a few edges
               repeat (6) @(posedge i_core_clk);
               rd_chk(`SKTD_ADR_STATUS, 32'(lv) << (p + 1));
               run_op(w, eh, 32'(lv == pol));
            end
         end
      end
      // Park both pins low and let the level event land before t_irq
      @(posedge i_core_clk);
      pin1 <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      $display("test pins done");
   endtask

   task automatic t_pwr;
      @(posedge i_core_clk);
      pwr <= 1'b1;
      run_op(`SKTD_OP_PWR_DOWN, 32'h8, 32'h1);
      @(posedge i_core_clk);
      pwr <= 1'b0;
      run_op(`SKTD_OP_PWR_DOWN, 32'h8, 32'h0);
      $display("test pwr done");
   endtask

   task automatic t_irq;
      logic [31:0] x;
      wb_cycle(1'b0, `SKTD_ADR_IRQ_STAT, 32'h0, x);
      wr(`SKTD_ADR_IRQ_MASK, 32'h2);
      pulse_conv();
      repeat (3) @(posedge i_core_clk);
      #1;
      chk(irq, 32'h1);
      rd_chk(`SKTD_ADR_IRQ_STAT, 32'h2);
      @(posedge i_core_clk);
      #1;
      chk(irq, 32'h0);
      wr(`SKTD_ADR_IRQ_MASK, 32'h0);
      pulse_conv();
      repeat (3) @(posedge i_core_clk);
      #1;
      chk(irq, 32'h0);
      $display("test irq done");
   endtask

   // Mid-run reset: registers, flag and a pending skip all return to zero
   task automatic t_reset;
      wr(`SKTD_ADR_CTL_TWO, 32'h4);
      pulse_conv();
      @(posedge i_core_clk);
      pwr <= 1'b1;
      issue_word(`SKTD_OP_PWR_DOWN);
      chk(skip, 32'h1);
      @(posedge i_core_clk);
      i_nrst <= 1'b0;
      pwr <= 1'b0;
      @(posedge i_core_clk);
      i_nrst <= 1'b1;
      #1;
      chk(skip, 32'h0);
      chk(ctl2, 32'h0);
      chk(flag, 32'h0);
      chk(irq, 32'h0);
      rd_chk(`SKTD_ADR_CTL_TWO, 32'h0);
      $display("test reset done");
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end

   initial begin
      repeat (2) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      t_regs();
      t_conv();
      t_pins();
      t_pwr();
      t_irq();
      t_reset();
      stop_test();
   end
endmodule
`default_nettype wire
